// [iotest_pkg.sv]
/*
 Package: register offsets, field positions, analog thresholds and timing counts
 of the I/O module test and indicator controller.
 Assumes a 100 MHz system clock.
*/
package iotest_pkg;
   localparam int unsigned CLK_HZ = 100_000_000;
   localparam int unsigned TICK_MS = 1;
   localparam int unsigned TICK_CYCLES = CLK_HZ / 1000 * TICK_MS;
   // Times in milliseconds, counted in ticks
   localparam int unsigned DEBOUNCE_MS = 20;
   localparam int unsigned QUICK_MS = 1000;
   localparam int unsigned PAUSE_MS = 2000;
   localparam int unsigned LEDTEST_MS = 5000;
   localparam int unsigned IDLE_MS = 30000;
   localparam int unsigned DEBOUNCE_TICKS = DEBOUNCE_MS / TICK_MS;
   localparam int unsigned PAUSE_TICKS = PAUSE_MS / TICK_MS;
   localparam int unsigned LEDTEST_TICKS = LEDTEST_MS / TICK_MS;
   localparam int unsigned IDLE_TICKS = IDLE_MS / TICK_MS;
   localparam int unsigned NCH = 6;
   // Analog thresholds (scaled units)
   localparam logic [15:0] FULL_SCALE = 16'h03e8;
   localparam logic [15:0] OVER_LIMIT = 16'h04b0;
   localparam logic [15:0] PF_LIMIT = 16'h0320;
   localparam logic [15:0] FREQ_LIMIT = 16'h01c2;
   // Register offsets
   localparam logic [7:0] CTRL_OFS = 8'h00;
   localparam logic [7:0] FORCE_OFS = 8'h04;
   localparam logic [7:0] STATUS_OFS = 8'h08;
   localparam logic [7:0] IRQ_STAT_OFS = 8'h0c;
   localparam logic [7:0] IRQ_EN_OFS = 8'h10;
   localparam logic [7:0] IRQ_CLR_OFS = 8'h14;
   // CTRL fields
   localparam int unsigned CTRL_FORCE_BIT = 0;
   localparam int unsigned CTRL_MODE_LSB = 1;
   localparam int unsigned CTRL_FAULT_BIT = 3;
   // FORCE fields
   localparam int unsigned FORCE_ZI_IN_BIT = 6;
   localparam int unsigned FORCE_ZI_OUT_BIT = 7;
   // Interrupt events
   localparam int unsigned EV_ENTER = 0;
   localparam int unsigned EV_LEAVE = 1;
   localparam int unsigned EV_BUTTON = 2;
   localparam int unsigned EV_LINK = 3;
   localparam int unsigned NEV = 4;
   // Module types
   localparam logic [1:0] MOD_INPUT = 2'h0;
   localparam logic [1:0] MOD_DOUT = 2'h1;
   localparam logic [1:0] MOD_AOUT = 2'h2;
   // LED colours
   localparam logic [1:0] LED_OFF = 2'h0;
   localparam logic [1:0] LED_GREEN = 2'h1;
   localparam logic [1:0] LED_YELLOW = 2'h2;
   localparam logic [1:0] LED_RED = 2'h3;
   typedef enum logic [1:0] {BTN_NONE, BTN_QUICK, BTN_AFTER_PAUSE} press_type;
endpackage

// [button_if.sv]
/*
 Interface: debounced button events and tick between button and sequencer.
 Assumes one clock domain.
*/
`timescale 1ns/100ps
interface button_if;
   logic tick;
   logic press;
   logic after_pause;
   modport src (output tick, output press, output after_pause);
   modport dst (input tick, input press, input after_pause);
endinterface

// [button_timer.sv]
/*
 Button debouncer and tick divider; flags presses that follow a long pause.
 Assumes button synchronous to clk, active high when pressed.
*/
`timescale 1ns/100ps
module button_timer
   import iotest_pkg::*;
(
   input wire logic clk,
   input wire logic rst_sync_n,
   input wire logic button,
   button_if.src bus
);
   logic [$clog2(TICK_CYCLES)-1:0] div_r;
   logic [7:0] deb_r;
   logic stable_r;
   logic [15:0] gap_r;
   logic tick;

   // ----------------------------------------
   // Tick divider
   // ----------------------------------------
   always_ff @(posedge clk or negedge rst_sync_n) begin
      if (!rst_sync_n) begin
         div_r <= '0;
      end else if (tick) begin
         div_r <= '0;
      end else begin
         div_r <= div_r + 1'b1;
      end
   end
   assign tick = (div_r == ($clog2(TICK_CYCLES))'(TICK_CYCLES - 1)); // [R19]

   // ----------------------------------------
   // Debounce
   // ----------------------------------------
   always_ff @(posedge clk or negedge rst_sync_n) begin
      if (!rst_sync_n) begin
         deb_r <= '0;
         stable_r <= 1'b0;
      end else if (button == stable_r) begin
         deb_r <= '0;
      end else if (tick) begin
         if (deb_r == 8'(DEBOUNCE_TICKS - 1)) begin
            stable_r <= button; // [R19]
            deb_r <= '0;
         end else begin
            deb_r <= deb_r + 1'b1;
         end
      end
   end

   // ----------------------------------------
   // Pause measurement since last release
   // ----------------------------------------
   always_ff @(posedge clk or negedge rst_sync_n) begin
      if (!rst_sync_n) begin
         gap_r <= '0;
      end else if (stable_r) begin
         gap_r <= '0;
      end else if (tick && gap_r != 16'hffff) begin
         gap_r <= gap_r + 1'b1; // [R19]
      end
   end

   assign bus.tick = tick;
   assign bus.press = tick && !stable_r && button && deb_r == 8'(DEBOUNCE_TICKS - 1);
   assign bus.after_pause = gap_r > 16'(PAUSE_TICKS); // [R11]
endmodule

// [iotest_ctrl.sv]
/*
 I/O module test and LED controller: status, bus-link and channel LEDs,
 button test sequence, remote forcing, AXI4-Lite registers and interrupt.
 Assumes clk at 100 MHz, inputs synchronous, link_detect from bus logic.
*/
// The placing of the registers and the AXI4-Lite slave port were decided locally.
// Operation
// [R1] Bus-link LED green while another module is detected, else off; the code also lights it green throughout the LED test.
// [R2] Input module: channel LED yellow when its input is high.
// [R3] Digital output module: channel LED yellow when output active.
// [R4] Analog output: yellow on 20% overrange, power factor over 0.8, frequency over 45 Hz.
// [R5] Channel LED dark when no yellow condition holds.
// [R6] Normal operation: states follow wiring or pending event signals.
// [R7] Press in normal operation enters test mode, clearing all channels and LEDs; the code keeps analog output channel LEDs lit by their analog limits.
// [R8] Entering test mode turns status LED from green to yellow.
// [R9] First test press selects channel one, shown by green LED.
// [R10] Quick press toggles selected channel on and off.
// [R11] Press after pause over 2 s advances to next channel.
// [R12] Input module test state is also sent over the module bus.
// [R13] Digital output test drives the physical output with its LED.
// [R14] After channel six, paused press starts LED test; 5 s timeout exits.
// [R15] Press within LED-test timeout restarts the sequence.
// [R16] Test mode ends after 30 s without press or remote change.
// [R17] Remote tool may force test mode and overwrite channels and zone interlock.
// [R18] Status LED red on fault, yellow in test or force, green otherwise.
// [R19] Button debounced and timed by a tick from the system clock.
`timescale 1ns/100ps
module iotest_ctrl
   import iotest_pkg::*;
#(
   parameter int unsigned IDLE_LIMIT = IDLE_TICKS,
   parameter int unsigned LEDTEST_LIMIT = LEDTEST_TICKS
)(
   input wire logic clk,
   input wire logic rst_n,
   input wire logic button,
   input wire logic link_detect,
   input wire logic internal_fault,
   input wire logic [NCH-1:0] wired_in,
   input wire logic [NCH-1:0] event_out,
   input wire logic [NCH*16-1:0] analog_value,
   input wire logic [NCH-1:0] analog_kind_pf,
   input wire logic [NCH-1:0] analog_kind_freq,
   input wire logic zone_interlock_in,
   input wire logic zone_interlock_evt,
   output logic [NCH-1:0] chan_state,
   output logic [NCH-1:0] phys_out,
   output logic zone_interlock_in_eff,
   output logic zone_interlock_out,
   output logic [1:0] status_led,
   output logic [1:0] link_led,
   output logic [NCH*2-1:0] chan_led,
   output logic irq,
   input wire logic [7:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [7:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready
);
   initial begin
      if (IDLE_LIMIT < 2 || IDLE_LIMIT > 65535 || LEDTEST_LIMIT < 2 || LEDTEST_LIMIT > 65535)
         $error("timeout limit out of range");
   end

   typedef enum logic [1:0] {ST_NORMAL, ST_TEST, ST_LEDTEST} state_type;

   logic rs1_r, rst_sync_n;
   state_type state_r;
   logic [2:0] sel_r;
   logic [NCH-1:0] test_val_r;
   logic [15:0] idle_r;
   logic force_r, fault_sw_r;
   logic [1:0] mod_r;
   logic [7:0] force_val_r;
   logic [NEV-1:0] irq_stat_r, irq_en_r, ev;
   logic link_d_r;
   logic aw_hold_r, w_hold_r;
   logic [7:0] awaddr_r;
   logic [31:0] wdata_r;
   logic wr_fire, remote_chg;
   logic [NCH-1:0] live_val, yellow;
   logic in_test;
   button_if btn();

   // ----------------------------------------
   // Reset release
   // ----------------------------------------
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         rs1_r <= 1'b0;
         rst_sync_n <= 1'b0;
      end else begin
         rs1_r <= 1'b1;
         rst_sync_n <= rs1_r;
      end
   end

   button_timer u_btn (
      .clk(clk),
      .rst_sync_n(rst_sync_n),
      .button(button),
      .bus(btn)
   );

   // ----------------------------------------
   // Test sequencer
   // ----------------------------------------
   assign remote_chg = wr_fire && (awaddr_r == CTRL_OFS || awaddr_r == FORCE_OFS);

   always_ff @(posedge clk or negedge rst_sync_n) begin
      if (!rst_sync_n) begin
         state_r <= ST_NORMAL;
         sel_r <= '0;
         test_val_r <= '0;
      end else begin
         case (state_r)
            ST_NORMAL: begin
               if (btn.press) begin
                  state_r <= ST_TEST; // [R7]
                  sel_r <= '0;
                  test_val_r <= '0; // [R7]
               end
            end
            ST_TEST: begin
               if (idle_r >= 16'(IDLE_LIMIT)) begin
                  state_r <= ST_NORMAL; // [R16]
                  sel_r <= '0;
               end else if (btn.press) begin
                  if (sel_r == 3'd0) begin
                     sel_r <= 3'd1; // [R9]
                  end else if (btn.after_pause) begin
                     if (sel_r == 3'(NCH)) begin
                        state_r <= ST_LEDTEST; // [R14]
                     end else begin
                        sel_r <= sel_r + 3'd1; // [R11]
                     end
                  end else begin
                     test_val_r[sel_r-3'd1] <= !test_val_r[sel_r-3'd1]; // [R10]
                  end
               end
            end
            ST_LEDTEST: begin
               if (btn.press) begin
                  state_r <= ST_TEST; // [R15]
                  sel_r <= '0;
                  test_val_r <= '0;
               end else if (idle_r >= 16'(LEDTEST_LIMIT)) begin
                  state_r <= ST_NORMAL; // [R14]
                  sel_r <= '0;
               end
            end
            default: state_r <= ST_NORMAL;
         endcase
      end
   end

   // Inactivity counter, cleared by any press or remote change
   always_ff @(posedge clk or negedge rst_sync_n) begin
      if (!rst_sync_n) begin
         idle_r <= '0;
      end else if (btn.press || remote_chg || state_r == ST_NORMAL) begin
         idle_r <= '0; // [R16]
      end else if (btn.tick && idle_r != 16'hffff) begin
         idle_r <= idle_r + 1'b1;
      end
   end

   // ----------------------------------------
   // Channel state and LEDs
   // ----------------------------------------
   assign in_test = state_r != ST_NORMAL || force_r;
   assign live_val = (mod_r == MOD_INPUT) ? wired_in : event_out; // [R6]

   generate
      for (genvar i = 0; i < NCH; i++) begin : g_ch
         logic [15:0] v;
         assign v = analog_value[i*16 +: 16];
         always_comb begin
            if (force_r) begin
               chan_state[i] = force_val_r[i]; // [R17]
            end else if (state_r != ST_NORMAL) begin
               chan_state[i] = test_val_r[i]; // [R12]
            end else begin
               chan_state[i] = live_val[i]; // [R6]
            end
            if (mod_r == MOD_AOUT) begin
               if (analog_kind_pf[i]) begin
                  yellow[i] = v > PF_LIMIT; // [R4]
               end else if (analog_kind_freq[i]) begin
                  yellow[i] = v > FREQ_LIMIT; // [R4]
               end else begin
                  yellow[i] = v > OVER_LIMIT; // [R4]
               end
            end else begin
               yellow[i] = chan_state[i]; // [R2] [R3]
            end
            if (state_r == ST_LEDTEST) begin
               chan_led[i*2 +: 2] = LED_YELLOW;
            end else if (state_r == ST_TEST && sel_r == 3'(i + 1) && !test_val_r[i]) begin
               chan_led[i*2 +: 2] = LED_GREEN; // [R9]
            end else begin
               chan_led[i*2 +: 2] = yellow[i] ? LED_YELLOW : LED_OFF; // [R5]
            end
         end
      end
   endgenerate

   always_ff @(posedge clk or negedge rst_sync_n) begin
      if (!rst_sync_n) begin
         phys_out <= '0;
         zone_interlock_in_eff <= 1'b0;
         zone_interlock_out <= 1'b0;
      end else begin
         phys_out <= (mod_r == MOD_DOUT) ? chan_state : '0; // [R13]
         zone_interlock_in_eff <= force_r ? force_val_r[FORCE_ZI_IN_BIT] : zone_interlock_in;
         zone_interlock_out <= force_r ? force_val_r[FORCE_ZI_OUT_BIT] : zone_interlock_evt; // [R17]
      end
   end

   always_comb begin
      if (internal_fault || fault_sw_r) begin
         status_led = LED_RED; // [R18]
      end else if (in_test) begin
         status_led = LED_YELLOW; // [R8]
      end else begin
         status_led = LED_GREEN;
      end
      link_led = (link_detect || state_r == ST_LEDTEST) ? LED_GREEN : LED_OFF; // [R1]
   end

   // ----------------------------------------
   // Interrupts
   // ----------------------------------------
   always_ff @(posedge clk or negedge rst_sync_n) begin
      if (!rst_sync_n) begin
         link_d_r <= 1'b0;
      end else begin
         link_d_r <= link_detect;
      end
   end
   always_comb begin
      ev = '0;
      ev[EV_ENTER] = state_r == ST_NORMAL && btn.press;
      ev[EV_LEAVE] = state_r != ST_NORMAL && idle_r >= 16'(IDLE_LIMIT);
      ev[EV_BUTTON] = btn.press;
      ev[EV_LINK] = link_detect != link_d_r;
   end
   always_ff @(posedge clk or negedge rst_sync_n) begin
      if (!rst_sync_n) begin
         irq_stat_r <= '0;
      end else begin
         for (int k = 0; k < NEV; k++) begin
            if (ev[k]) begin
               irq_stat_r[k] <= 1'b1;
            end else if (wr_fire && awaddr_r == IRQ_CLR_OFS && wdata_r[k]) begin
               irq_stat_r[k] <= 1'b0;
            end
         end
      end
   end
   assign irq = |(irq_stat_r & irq_en_r);

   // ----------------------------------------
   // AXI4-Lite write
   // ----------------------------------------
   assign s_axi_awready = !aw_hold_r && !s_axi_bvalid;
   assign s_axi_wready = !w_hold_r && !s_axi_bvalid;
   assign wr_fire = aw_hold_r && w_hold_r;
   assign s_axi_bresp = 2'h0;

   always_ff @(posedge clk or negedge rst_sync_n) begin
      if (!rst_sync_n) begin
         aw_hold_r <= 1'b0;
         w_hold_r <= 1'b0;
         awaddr_r <= '0;
         wdata_r <= '0;
         s_axi_bvalid <= 1'b0;
      end else begin
         if (s_axi_awvalid && s_axi_awready) begin
            aw_hold_r <= 1'b1;
            awaddr_r <= s_axi_awaddr;
         end
         if (s_axi_wvalid && s_axi_wready) begin
            w_hold_r <= 1'b1;
            wdata_r <= s_axi_wdata;
         end
         if (wr_fire) begin
            aw_hold_r <= 1'b0;
            w_hold_r <= 1'b0;
            s_axi_bvalid <= 1'b1;
         end else if (s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
         end
      end
   end

   always_ff @(posedge clk or negedge rst_sync_n) begin
      if (!rst_sync_n) begin
         force_r <= 1'b0;
         mod_r <= MOD_INPUT;
         fault_sw_r <= 1'b0;
         force_val_r <= '0;
         irq_en_r <= '0;
      end else if (wr_fire) begin
         case (awaddr_r)
            CTRL_OFS: begin
               force_r <= wdata_r[CTRL_FORCE_BIT]; // [R17]
               mod_r <= wdata_r[CTRL_MODE_LSB +: 2];
               fault_sw_r <= wdata_r[CTRL_FAULT_BIT];
            end
            FORCE_OFS: force_val_r <= wdata_r[7:0]; // [R17]
            IRQ_EN_OFS: irq_en_r <= wdata_r[NEV-1:0];
            default: ;
         endcase
      end
   end

   // ----------------------------------------
   // AXI4-Lite read
   // ----------------------------------------
   assign s_axi_arready = !s_axi_rvalid;
   assign s_axi_rresp = 2'h0;
   always_ff @(posedge clk or negedge rst_sync_n) begin
      if (!rst_sync_n) begin
         s_axi_rvalid <= 1'b0;
         s_axi_rdata <= '0;
      end else if (s_axi_arvalid && s_axi_arready) begin
         s_axi_rvalid <= 1'b1;
         case (s_axi_araddr)
            CTRL_OFS: s_axi_rdata <= {28'h0, fault_sw_r, mod_r, force_r};
            FORCE_OFS: s_axi_rdata <= {24'h0, force_val_r};
            STATUS_OFS: s_axi_rdata <= {16'h0, 2'(state_r), 3'h0, sel_r, 2'h0, chan_state};
            IRQ_STAT_OFS: s_axi_rdata <= {28'h0, irq_stat_r};
            IRQ_EN_OFS: s_axi_rdata <= {28'h0, irq_en_r};
            default: s_axi_rdata <= 32'h0;
         endcase
      end else if (s_axi_rready) begin
         s_axi_rvalid <= 1'b0;
      end
   end
endmodule

// [iotest_ctrl_sva.sv]
/*
 Checker on the controller's top ports.
 Assumes one clock domain.
*/
`timescale 1ns/100ps
module iotest_ctrl_sva
   import iotest_pkg::*;
#(
   parameter int unsigned IDLE_LIMIT = IDLE_TICKS,
   parameter int unsigned LEDTEST_LIMIT = LEDTEST_TICKS
)(
   input wire logic clk,
   input wire logic rst_n,
   input wire logic link_detect,
   input wire logic internal_fault,
   input wire logic zone_interlock_in,
   input wire logic zone_interlock_evt,
   input wire logic [NCH-1:0] chan_state,
   input wire logic [NCH-1:0] phys_out,
   input wire logic zone_interlock_in_eff,
   input wire logic zone_interlock_out,
   input wire logic [1:0] status_led,
   input wire logic [1:0] link_led,
   input wire logic [NCH*2-1:0] chan_led
);
   logic [1:0] up_r;
   logic odd_led;

   default clocking cb @(posedge clk); endclocking
   default disable iff (!rst_n);

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) up_r <= 2'h0;
      else if (up_r != 2'h3) up_r <= up_r + 2'h1;
   end

   always_comb begin
      odd_led = 1'b0;
      for (int i = 0; i < NCH; i++) begin
         odd_led = odd_led | (chan_led[2*i+:2] inside {LED_GREEN, LED_RED});
      end
   end

   link_on_a: assert property (link_detect |-> link_led == LED_GREEN)
      else $error("link LED off");
   link_off_a: assert property (
      !link_detect && status_led == LED_GREEN |-> link_led == LED_OFF)
      else $error("link LED lit");
   fault_red_a: assert property (internal_fault |-> status_led == LED_RED)
      else $error("no red on fault");
   status_lit_a: assert property (status_led != LED_OFF)
      else $error("status LED dark");
   chan_colour_a: assert property (status_led == LED_GREEN |-> !odd_led)
      else $error("odd channel colour");
   phys_follow_a: assert property (
      up_r == 2'h3 |=> phys_out == 6'h00 || phys_out == $past(chan_state))
      else $error("phys_out stale");
   zi_out_live_a: assert property (
      up_r == 2'h3 && status_led == LED_GREEN |=>
      zone_interlock_out == $past(zone_interlock_evt))
      else $error("zone out not live");
   zi_in_live_a: assert property (
      up_r == 2'h3 && status_led == LED_GREEN |=>
      zone_interlock_in_eff == $past(zone_interlock_in))
      else $error("zone in not live");
endmodule

bind iotest_ctrl iotest_ctrl_sva #(.IDLE_LIMIT(IDLE_LIMIT), .LEDTEST_LIMIT(LEDTEST_LIMIT))
   iotest_ctrl_sva_i (.*);

// [bus_peer.sv]
/*
 Module bus peer model.
 Assumes bench-set levels; one or two cycles latency.
*/
`timescale 1ns/100ps
module bus_peer (
   input wire logic clk,
   input wire logic slow,
   input wire logic present,
   input wire logic [5:0] pending,
   input wire logic zin,
   input wire logic zevt,
   output logic link_detect,
   output logic [5:0] event_out,
   output logic zone_interlock_in,
   output logic zone_interlock_evt
);
   logic [8:0] s1_r;
   logic [8:0] s2_r;

   always_ff @(posedge clk) begin
      s1_r <= {present, pending, zin, zevt};
      s2_r <= s1_r;
   end

   // Slow peer answers one cycle later
   assign {link_detect, event_out, zone_interlock_in, zone_interlock_evt} = slow ? s2_r : s1_r;
endmodule

// [iotest_ctrl_bench.sv]
/*
 Self-checking controller bench.
 Assumes the bus peer model.
*/
`timescale 1ns/100ps
module iotest_ctrl_bench;
   import iotest_pkg::*;
   typedef struct {logic [31:0] v; logic [31:0] m;} note_type;
   note_type snap_q[$], rd_q[$];
   int n_errors = 0, checks = 0, cyc = 0;
   logic clk = 1'b0, rst_n = 1'b0, button = 1'b0, internal_fault = 1'b0, probe = 1'b0;
   logic slow = 1'b0, present = 1'b0, zin = 1'b0, zevt = 1'b0, irq_exp = 1'b0;
   logic [5:0] pending = 6'h00, wired_in = 6'h00, kpf;
   logic [5:0] analog_kind_pf = 6'h00, analog_kind_freq = 6'h00;
   logic [NCH*16-1:0] analog_value = '0;
   logic [31:0] ctrl = 32'h0, s_axi_wdata = 32'h0;
   logic [7:0] freg = 8'h00, s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00, f = 8'h00;
   logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_arvalid = 1'b0;
   logic link_detect, zone_interlock_in, zone_interlock_evt, zone_interlock_in_eff;
   logic zone_interlock_out, irq, s_axi_awready, s_axi_wready, s_axi_bvalid;
   logic s_axi_arready, s_axi_rvalid;
   logic [5:0] event_out, chan_state, phys_out;
   logic [1:0] status_led, link_led, s_axi_bresp, s_axi_rresp;
   logic [11:0] chan_led;
   logic [31:0] s_axi_rdata;

   always #5 clk = ~clk;

   bus_peer bus_peer_i (.clk(clk), .slow(slow), .present(present), .pending(pending),
      .zin(zin), .zevt(zevt), .link_detect(link_detect), .event_out(event_out),
      .zone_interlock_in(zone_interlock_in), .zone_interlock_evt(zone_interlock_evt));

   iotest_ctrl #(.IDLE_LIMIT(20), .LEDTEST_LIMIT(20)) iotest_ctrl_i (.clk(clk), .rst_n(rst_n),
      .button(button), .link_detect(link_detect), .internal_fault(internal_fault),
      .wired_in(wired_in), .event_out(event_out), .analog_value(analog_value),
      .analog_kind_pf(analog_kind_pf), .analog_kind_freq(analog_kind_freq),
      .zone_interlock_in(zone_interlock_in), .zone_interlock_evt(zone_interlock_evt),
      .chan_state(chan_state), .phys_out(phys_out), .zone_interlock_in_eff(zone_interlock_in_eff),
      .zone_interlock_out(zone_interlock_out), .status_led(status_led), .link_led(link_led),
      .chan_led(chan_led), .irq(irq), .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid),
      .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(4'hf),
      .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
      .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(1'b1), .s_axi_araddr(s_axi_araddr),
      .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
      .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(1'b1));

   // ----------------------------------------
   // Expectations
   // ----------------------------------------
   function automatic logic [31:0] snap_exp();
      logic [5:0] cs;
      logic [11:0] led;
      logic [15:0] lim;
      logic [1:0] mt;
      logic frc;
      mt = ctrl[CTRL_MODE_LSB+:2];
      frc = ctrl[CTRL_FORCE_BIT];
      cs = frc ? freg[5:0] : (mt == MOD_INPUT) ? wired_in : event_out;
      led = 12'h000;
      for (int i = 0; i < NCH; i++) begin
         lim = analog_kind_pf[i] ? PF_LIMIT : analog_kind_freq[i] ? FREQ_LIMIT : OVER_LIMIT;
         if ((mt == MOD_AOUT) ? (analog_value[16*i+:16] > lim) : cs[i]) led[2*i+:2] = LED_YELLOW;
      end
      return {1'b0, cs, (mt == MOD_DOUT) ? cs : 6'h00,
         frc ? freg[FORCE_ZI_IN_BIT] : zone_interlock_in,
         frc ? freg[FORCE_ZI_OUT_BIT] : zone_interlock_evt,
         (internal_fault | ctrl[CTRL_FAULT_BIT]) ? LED_RED : frc ? LED_YELLOW : LED_GREEN,
         link_detect ? LED_GREEN : LED_OFF, led, irq_exp};
   endfunction

   task automatic judge(input string what, input note_type n, input logic [31:0] s);
      checks++;
      if ((s & n.m) !== (n.v & n.m)) begin
         n_errors++;
         $display("BAD %s exp %h seen %h", what, n.v & n.m, s & n.m);
      end
   endtask

   task automatic cmp_snap(input note_type n);
      judge("outputs", n, {1'b0, chan_state, phys_out, zone_interlock_in_eff,
         zone_interlock_out, status_led, link_led, chan_led, irq});
   endtask

   task automatic cmp_read(input note_type n);
      judge("read data", n, s_axi_rdata);
   endtask

   always @(negedge clk) begin
      if (probe) cmp_snap(snap_q.pop_front());
      if (s_axi_rvalid) cmp_read(rd_q.pop_front());
      cyc <= cyc + 1;
      if (cyc == 30000) begin
         n_errors++;
         conclude();
      end
   end

   // ----------------------------------------
   // Drivers
   // ----------------------------------------
   task automatic look(input logic [31:0] m);
      repeat (4) @(posedge clk);
      snap_q.push_back('{snap_exp(), m});
      probe <= 1'b1;
      @(posedge clk);
      probe <= 1'b0;
   endtask

   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      s_axi_awaddr <= a;
      s_axi_wdata <= d;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      do begin
         @(posedge clk);
         if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
         if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
      end while (!s_axi_bvalid);
      if (a == CTRL_OFS) ctrl = d;
      if (a == FORCE_OFS) freg = d[7:0];
   endtask

   task automatic rd(input logic [7:0] a, input logic [31:0] v, input logic [31:0] m);
      rd_q.push_back('{v, m});
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      do begin
         @(posedge clk);
         if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
      end while (!s_axi_rvalid);
   endtask

   task automatic shake(input bit edge_case);
      logic [NCH*16-1:0] av;
      for (int i = 0; i < NCH; i++) av[16*i+:16] = 16'($urandom_range(16'h04c0, 16'h01a0));
      kpf = 6'($urandom);
      wired_in <= 6'($urandom);
      pending <= 6'($urandom);
      present <= 1'($urandom);
      slow <= 1'($urandom);
      zin <= 1'($urandom);
      zevt <= 1'($urandom);
      analog_kind_pf <= edge_case ? 6'h0c : kpf;
      analog_kind_freq <= edge_case ? 6'h30 : 6'($urandom) & ~kpf;
      analog_value <= edge_case ? {16'h01c3, 16'h01c2, 16'h0321, 16'h0320, 16'h04b1, 16'h04b0} : av;
   endtask

   task automatic conclude();
      if (n_errors == 0 && checks > 0) begin
         $display("ALL CHECKS OK");
      end else begin
         $display("CHECKS NOT OK");
      end
      $finish;
   endtask

   // ----------------------------------------
   // Main sequence
   // ----------------------------------------
   initial begin
      void'($urandom(32'he135));
      repeat (6) @(posedge clk);
      rst_n <= 1'b1;
      repeat (3) @(posedge clk);
      rd(CTRL_OFS, 32'h0, '1);
      rd(FORCE_OFS, 32'h0, '1);
      rd(IRQ_EN_OFS, 32'h0, '1);
      wr(8'h3c, 32'hffff_ffff);
      rd(8'h3c, 32'h0, '1);
      for (int t = 0; t < 3; t++) begin
         wr(CTRL_OFS, 32'(t) << CTRL_MODE_LSB);
         for (int k = 0; k < 6; k++) begin
            shake(k == 0);
            look((t == 2) ? 32'h0007_fffe : 32'h7fff_fffe);
         end
      end
      for (int t = 0; t < 2; t++) begin
         for (int k = 0; k < 3; k++) begin
            f = 8'($urandom);
            wr(CTRL_OFS, (32'(t) << CTRL_MODE_LSB) | 32'h1);
            wr(FORCE_OFS, {24'h0, f});
            look(32'h7fff_fffe);
            rd(STATUS_OFS, {26'h0, f[5:0]}, 32'h3f);
         end
         shake(1'b0);
         wr(CTRL_OFS, 32'(t) << CTRL_MODE_LSB);
         look(32'h7fff_fffe);
      end
      internal_fault <= 1'b1;
      look(32'h7fff_fffe);
      internal_fault <= 1'b0;
      wr(CTRL_OFS, 32'h1 << CTRL_FAULT_BIT);
      look(32'h7fff_fffe);
      wr(CTRL_OFS, 32'h0);
      wr(IRQ_CLR_OFS, 32'hf);
      wr(IRQ_EN_OFS, 32'h1 << EV_LINK);
      present <= ~present;
      irq_exp = 1'b1;
      look(32'h7fff_ffff);
      rd(IRQ_STAT_OFS, 32'h8, 32'h8);
      wr(IRQ_EN_OFS, 32'h0);
      irq_exp = 1'b0;
      look(32'h1);
      wr(IRQ_EN_OFS, 32'h1 << EV_LINK);
      irq_exp = 1'b1;
      look(32'h1);
      wr(IRQ_CLR_OFS, 32'h1 << EV_LINK);
      irq_exp = 1'b0;
      look(32'h1);
      rd(IRQ_STAT_OFS, 32'h0, 32'h8);
      repeat (2) @(posedge clk);
      conclude();
   end
endmodule
